// ### logic/fds_ctrl.sv
// Purpose: controller end; selects one drive, steps, then transfers
// Assumes: status pins arrive from another domain
// Notes:   settle count is a parameter to allow short simulation
`timescale 1ns/1ps
`include "fds_defines.svh"
module fds_ctrl #(
    parameter int unsigned SETTLE_CYC = `FDS_SETTLE_CYC
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // user request
    input  wire logic       req_valid,
    output logic            req_ready,
    input  wire logic [1:0] req_drive,
    input  wire logic [7:0] req_steps,
    input  wire logic       req_dir,
    input  wire logic       req_write,
    input  wire logic       req_wdata,
    output logic            busy,
    output logic            done,
    output logic            track_zero,
    output logic            read_bit,
    // cable
    fds_link_if.ctrl        link
);
    fds_pkg::fds_state_t state;
    logic [3:0]  pick_n;
    logic [7:0]  steps_left;
    logic [7:0]  ph_cnt;
    logic [31:0] settle_cnt;
    logic        wr;
    logic [3:0]  st_s1;
    logic [3:0]  st_s2;

    assign req_ready = (state == fds_pkg::FDS_IDLE);
    assign busy      = !req_ready;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state      <= fds_pkg::FDS_IDLE;
            pick_n     <= 4'hf;
            steps_left <= 8'h00;
            ph_cnt     <= 8'h00;
            settle_cnt <= 32'h0;
            wr         <= 1'b0;
            done       <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                fds_pkg::FDS_IDLE: begin
                    pick_n <= 4'hf;
                    if (req_valid) begin
                        // one-hot select so only one line is ever low
                        pick_n     <= ~(4'h1 << req_drive);     // [R1] [R5]
                        steps_left <= req_steps;
                        wr         <= req_write;
                        ph_cnt     <= 8'h00;
                        state      <= fds_pkg::FDS_STEP;
                    end
                end
                fds_pkg::FDS_STEP: begin
                    if (steps_left == 8'h00) begin
                        settle_cnt <= 32'h0;
                        state      <= fds_pkg::FDS_SETTLE;
                    end else if (ph_cnt == `FDS_STEP_HI_CYC + `FDS_STEP_LO_CYC - 8'h01) begin
                        ph_cnt     <= 8'h00;
                        steps_left <= steps_left - 8'h01;
                    end else begin
                        ph_cnt <= ph_cnt + 8'h01;
                    end
                end
                fds_pkg::FDS_SETTLE: begin
                    // full settle even after zero steps, re-seating after power-save
                    if (settle_cnt >= SETTLE_CYC - 1) begin      // [R10] [R9]
                        state <= fds_pkg::FDS_XFER;
                    end else begin
                        settle_cnt <= settle_cnt + 32'h1;
                    end
                end
                fds_pkg::FDS_XFER: begin
                    // select held low through here, released only when done
                    if (!req_valid) begin                         // [R4]
                        done  <= 1'b1;
                        state <= fds_pkg::FDS_IDLE;
                        pick_n <= 4'hf;
                    end
                end
                default: state <= fds_pkg::FDS_IDLE;
            endcase
        end
    end

    assign link.drive_pick_zero_n  = pick_n[0];
    assign link.drive_pick_one_n   = pick_n[1];
    assign link.drive_pick_two_n   = pick_n[2];
    assign link.drive_pick_three_n = pick_n[3];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            link.step_n       <= 1'b1;
            link.dir_in       <= 1'b0;
            link.write_gate_n <= 1'b1;
            link.write_data_n <= 1'b1;
        end else begin
            link.step_n       <= !(state == fds_pkg::FDS_STEP && steps_left != 8'h00
                                   && ph_cnt < `FDS_STEP_LO_CYC);
            link.dir_in       <= req_dir;
            // gate rises on the same edge that releases the select, never after
            link.write_gate_n <= !(state == fds_pkg::FDS_XFER && wr
                                   && req_valid);                           // [R4]
            link.write_data_n <= !(state == fds_pkg::FDS_XFER && wr
                                   && req_valid && req_wdata);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_s1      <= 4'h5;
            st_s2      <= 4'h5;
            track_zero <= 1'b0;
            read_bit   <= 1'b0;
        end else begin
            // enable and level synchronised apart, combined only after two flops
            st_s1      <= {link.track_zero_oe, link.track_zero_n,
                           link.read_data_oe, link.read_data_n};
            st_s2      <= st_s1;
            track_zero <= st_s2[3] && !st_s2[2];
            read_bit   <= st_s2[1] && !st_s2[0];
        end
    end
endmodule : fds_ctrl

// ### logic/fds_defines.svh
// Purpose: shared constants for the drive-select link
// Assumes: 20 MHz mclk
// Notes:   settle count derives from a time in its own units; step counts are given in cycles
`ifndef FDS_DEFINES_SVH
`define FDS_DEFINES_SVH
`define FDS_NUM_DRIVES      4
`define FDS_CLK_MHZ         20
`define FDS_SETTLE_MS       20
`define FDS_SETTLE_CYC      (`FDS_SETTLE_MS * 1000 * `FDS_CLK_MHZ)
`define FDS_STEP_HI_CYC     8'h14
`define FDS_STEP_LO_CYC     8'h14
`endif

// ### logic/fds_drive.sv
// Purpose: drive end; with the multiplex option responds only to its own select line
// Assumes: select, step, write and direction pins arrive from another domain
// Notes:   mechanism inputs pass two flops as well before any logic reads them
// How it works
// (R1) controller drives four active-low select lines
// (R2) selected drive accepts step and read/write
// (R3) deselected drive ignores inputs, disables status
// (R4) select stays low until operation completes
// (R5) at most one select line low
// (R6) board address picks which select line
// (R7) multiplex option gates lines by select
// (R8) power-save cuts stepper power when deselected
// (R9) controller re-seeks track after power-save reselect; here no re-seek, only the full settle, even after zero steps
// (R10) wait settling time after last step
`timescale 1ns/1ps
module fds_drive (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // board straps
    input  wire logic [1:0] drive_address,
    input  wire logic       multiplex_config_option,
    input  wire logic       stepper_power_save_option,
    input  wire logic       stepper_power_always_option,
    // mechanism side
    input  wire logic       head_read_pulse,
    input  wire logic       at_track_zero,
    output logic            electronics_on,
    output logic            stepper_power,
    output logic            step_pulse,
    output logic            step_dir,
    output logic            write_active,
    output logic            write_pulse,
    // cable
    fds_link_if.drive       link
);
    logic [3:0] pick_s1;
    logic [3:0] pick_s2;
    logic [2:0] in_s1;
    logic [2:0] in_s2;
    logic [2:0] in_d;
    logic [2:0] mech_s1;
    logic [2:0] mech_s2;
    logic       sel;
    logic       gate;

    // two-flop synchronisers, one per pin
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pick_s1 <= 4'hf;
            pick_s2 <= 4'hf;
            in_s1   <= 3'h7;
            in_s2   <= 3'h7;
            in_d    <= 3'h7;
            mech_s1 <= 3'h0;
            mech_s2 <= 3'h0;
        end else begin
            pick_s1 <= {link.drive_pick_three_n, link.drive_pick_two_n,
                        link.drive_pick_one_n, link.drive_pick_zero_n};
            pick_s2 <= pick_s1;
            in_s1   <= {link.step_n, link.write_gate_n, link.write_data_n};
            in_s2   <= in_s1;
            in_d    <= in_s2;
            // direction level plus head status, all asynchronous to mclk
            mech_s1 <= {link.dir_in, head_read_pulse, at_track_zero};
            mech_s2 <= mech_s1;
        end
    end

    assign sel  = !pick_s2[drive_address];           // [R6]
    // single-drive default keeps the lines live; multiplexed gates them
    assign gate = sel || !multiplex_config_option;   // [R7]

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            electronics_on <= 1'b0;
            stepper_power  <= 1'b0;
        end else begin
            electronics_on <= sel;                                          // [R2]
            // power-save only when fitted instead of the always jumper
            stepper_power  <= sel || stepper_power_always_option
                              || !stepper_power_save_option;                // [R8]
        end
    end

    // falling edge of step accepted only while gated in
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            step_pulse   <= 1'b0;
            step_dir     <= 1'b0;
            write_active <= 1'b0;
            write_pulse  <= 1'b0;
        end else begin
            step_pulse   <= gate && in_d[2] && !in_s2[2];                   // [R2] [R3]
            step_dir     <= mech_s2[2];
            write_active <= gate && !in_s2[1];                              // [R2] [R3]
            write_pulse  <= gate && !in_s2[1] && in_d[0] && !in_s2[0];      // [R3]
        end
    end

    // status outputs: driven only while gated
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            link.read_data_n   <= 1'b1;
            link.read_data_oe  <= 1'b0;
            link.track_zero_n  <= 1'b1;
            link.track_zero_oe <= 1'b0;
        end else begin
            link.read_data_oe  <= gate;                                     // [R3]
            link.track_zero_oe <= gate;                                     // [R3]
            link.read_data_n   <= !(gate && mech_s2[1]);
            link.track_zero_n  <= !(gate && mech_s2[0]);
        end
    end
endmodule : fds_drive

// ### logic/fds_link_if.sv
// Purpose: drive interface cable between controller and drive
// Assumes: one drive end per instance; shared bus resolved by the bench
// Notes:   active-low pins; status outputs have enables
`timescale 1ns/1ps
interface fds_link_if;
    logic drive_pick_zero_n;
    logic drive_pick_one_n;
    logic drive_pick_two_n;
    logic drive_pick_three_n;
    logic step_n;
    logic dir_in;
    logic write_gate_n;
    logic write_data_n;
    logic read_data_n;
    logic read_data_oe;
    logic track_zero_n;
    logic track_zero_oe;
    modport ctrl (
        output drive_pick_zero_n, drive_pick_one_n, drive_pick_two_n, drive_pick_three_n,
        output step_n, dir_in, write_gate_n, write_data_n,
        input  read_data_n, read_data_oe, track_zero_n, track_zero_oe
    );
    modport drive (
        input  drive_pick_zero_n, drive_pick_one_n, drive_pick_two_n, drive_pick_three_n,
        input  step_n, dir_in, write_gate_n, write_data_n,
        output read_data_n, read_data_oe, track_zero_n, track_zero_oe
    );
endinterface : fds_link_if

// ### logic/fds_pkg.sv
// Purpose: types for the drive-select link
// Assumes: nothing
// Notes:   one-hot controller states
package fds_pkg;
    typedef enum logic [3:0] {
        FDS_IDLE   = 4'b0001,
        FDS_STEP   = 4'b0010,
        FDS_SETTLE = 4'b0100,
        FDS_XFER   = 4'b1000
    } fds_state_t;
endpackage : fds_pkg

// ### verif/fds_link_assertions.sv
// Purpose: protocol checks on the drive cable
// Assumes: one drive end, strapped to DRV_ADDR
// Notes:   drive outputs trail the select pins by three edges
`timescale 1ns/1ps
module fds_link_assertions #(
    parameter int unsigned SETTLE_CYC = 50,
    parameter logic [1:0]  DRV_ADDR   = 2'h2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // strap
    input wire logic multiplex_config_option,
    // cable
    input wire logic drive_pick_zero_n,
    input wire logic drive_pick_one_n,
    input wire logic drive_pick_two_n,
    input wire logic drive_pick_three_n,
    input wire logic step_n,
    input wire logic write_gate_n,
    input wire logic read_data_oe,
    input wire logic track_zero_oe
);
    logic [3:0]  picks_n;
    logic [31:0] since_step;
    assign picks_n = {drive_pick_three_n, drive_pick_two_n, drive_pick_one_n, drive_pick_zero_n};
    // saturates so that an op without steps is not flagged
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) since_step <= '1;
        else if (!step_n) since_step <= '0;
        else if (since_step != '1) since_step <= since_step + 32'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence own_held;
        (!picks_n[DRV_ADDR]) [*4];
    endsequence
    sequence own_off;
        (multiplex_config_option && picks_n[DRV_ADDR]) [*4];
    endsequence
    chk_one_pick: assert property ($onehot0(~picks_n))
        else $error("two select lines low");
    chk_step_pick: assert property (!step_n |-> !(&picks_n))
        else $error("step with no drive selected");
    chk_write_pick: assert property (!write_gate_n |-> !(&picks_n))
        else $error("write gate with no drive selected");
    chk_step_width: assert property ($fell(step_n) |-> ##19 !step_n ##1 step_n)
        else $error("step pulse width off");
    chk_pick_steady: assert property ((!step_n || !write_gate_n) [*2] |-> $stable(picks_n))
        else $error("select moved during operation");
    chk_settle_gap: assert property ($fell(write_gate_n) |-> since_step >= SETTLE_CYC)
        else $error("write began before settling");
    chk_quiet_deselect: assert property (own_off |-> !read_data_oe && !track_zero_oe)
        else $error("deselected drive still driving");
    chk_own_drives: assert property (own_held |-> read_data_oe && track_zero_oe)
        else $error("selected drive not driving");
endmodule : fds_link_assertions

// ### verif/testbench.sv
// Purpose: end-to-end bench of controller and drive
// Assumes: drive strapped to address 2, short settle count
// Notes:   straps change only under reset
`timescale 1ns/1ps
module testbench;
    logic       mclk = 1'b0;
    logic       rst_b = 1'b0;
    logic       req_valid = 1'b0, req_dir = 1'b0, req_write = 1'b0, req_wdata = 1'b0;
    logic [1:0] req_drive = 2'h0;
    logic [7:0] req_steps = 8'h00;
    logic       mux = 1'b1, save = 1'b0, always_opt = 1'b1, rd_pulse = 1'b0, at_tz = 1'b1;
    logic       req_ready, busy, done, track_zero, read_bit;
    logic       el_on, st_pwr, st_pulse, st_dir, wr_act, wr_pulse, exp_dir = 1'b0;
    int         n_errors = 0, checked = 0, steps = 0, wpulses = 0, bad_dir = 0;
    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        steps <= steps + int'(st_pulse);
        wpulses <= wpulses + int'(wr_pulse);
        if (st_pulse && st_dir !== exp_dir) bad_dir <= bad_dir + 1;
    end
    fds_link_if link ();
    fds_ctrl #(.SETTLE_CYC(50)) u_fds_ctrl (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid),
        .req_ready(req_ready), .req_drive(req_drive), .req_steps(req_steps), .req_dir(req_dir),
        .req_write(req_write), .req_wdata(req_wdata), .busy(busy), .done(done),
        .track_zero(track_zero), .read_bit(read_bit), .link(link.ctrl));
    fds_drive u_fds_drive (.mclk(mclk), .rst_b(rst_b), .drive_address(2'h2),
        .multiplex_config_option(mux), .stepper_power_save_option(save),
        .stepper_power_always_option(always_opt), .head_read_pulse(rd_pulse),
        .at_track_zero(at_tz), .electronics_on(el_on), .stepper_power(st_pwr),
        .step_pulse(st_pulse), .step_dir(st_dir), .write_active(wr_act),
        .write_pulse(wr_pulse), .link(link.drive));
    fds_link_assertions #(.SETTLE_CYC(50), .DRV_ADDR(2'h2)) u_chk (.mclk(mclk), .rst_b(rst_b),
        .multiplex_config_option(mux), .drive_pick_zero_n(link.drive_pick_zero_n),
        .drive_pick_one_n(link.drive_pick_one_n), .drive_pick_two_n(link.drive_pick_two_n),
        .drive_pick_three_n(link.drive_pick_three_n), .step_n(link.step_n),
        .write_gate_n(link.write_gate_n), .read_data_oe(link.read_data_oe),
        .track_zero_oe(link.track_zero_oe));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        $display("counts: %0d checks, %0d mismatches", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic restart(input logic m, input logic s);
        @(posedge mclk);
        rst_b <= 1'b0;
        mux <= m;
        save <= s;
        always_opt <= ~s;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask : restart
    // act: drive should obey the cable, on: drive should count as selected
    // w: request a write gate for the transfer
    task automatic run_op(input logic [1:0] drv, input logic [7:0] n, input logic act,
                          input logic on, input logic w);
        int s0, w0;
        s0 = steps;
        w0 = wpulses;
        @(posedge mclk);
        req_valid <= 1'b1;
        req_drive <= drv;
        req_steps <= n;
        req_dir <= n[0];
        exp_dir <= n[0];
        req_write <= w;
        repeat (int'(n) * 40 + 70) @(posedge mclk);
        check("busy", {7'h0, busy}, 8'h01);
        check("electronics_on", {7'h0, el_on}, {7'h0, on});
        check("write_active", {7'h0, wr_act}, {7'h0, act && w});
        if (on) check("stepper_power", {7'h0, st_pwr}, 8'h01);
        rd_pulse <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            repeat (8) @(posedge mclk);
            req_wdata <= ~req_wdata;
        end
        if (act) check("read_bit", {7'h0, read_bit}, 8'h01);
        if (act) check("track_zero", {7'h0, track_zero}, 8'h01);
        check("track_zero_oe", {7'h0, link.track_zero_oe}, {7'h0, act});
        rd_pulse <= 1'b0;
        req_valid <= 1'b0;
        repeat (20) begin
            @(posedge mclk);
            #1;
            if (done === 1'b1) break;
        end
        check("done", {7'h0, done}, 8'h01);
        check("req_ready", {7'h0, req_ready}, 8'h01);
        check("steps", 8'(steps - s0), act ? n : 8'h00);
        check("write_pulses", 8'(wpulses - w0), (act && w) ? 8'h03 : 8'h00);
        check("step_dir", 8'(bad_dir), 8'h00);
    endtask : run_op
    task automatic test_selected;
        restart(1'b1, 1'b0);
        run_op(2'h2, 8'h03, 1'b1, 1'b1, 1'b1);
        run_op(2'h2, 8'h00, 1'b1, 1'b1, 1'b0);
        check("stepper_power", {7'h0, st_pwr}, 8'h01);
        $display("test selected finished");
    endtask : test_selected
    task automatic test_other;
        restart(1'b1, 1'b0);
        run_op(2'h1, 8'h02, 1'b0, 1'b0, 1'b1);
        $display("test other finished");
    endtask : test_other
    task automatic test_single;
        restart(1'b0, 1'b0);
        run_op(2'h0, 8'h01, 1'b1, 1'b0, 1'b1);
        $display("test single finished");
    endtask : test_single
    task automatic test_save;
        restart(1'b1, 1'b1);
        check("stepper_power", {7'h0, st_pwr}, 8'h00);
        run_op(2'h2, 8'h01, 1'b1, 1'b1, 1'b1);
        repeat (6) @(posedge mclk);
        check("stepper_power", {7'h0, st_pwr}, 8'h00);
        $display("test save finished");
    endtask : test_save
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        wrap_up();
    end
    initial begin
        test_selected();
        test_other();
        test_single();
        test_save();
        wrap_up();
    end
endmodule : testbench
